// ===== include/snd_pkg.sv
package snd_pkg;
    // Opcodes
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_GETF   = 8'h0f;
    localparam logic [7:0] OP_SETF   = 8'h1f;
    localparam logic [7:0] OP_PRD    = 8'h13;
    localparam logic [7:0] OP_RCACHE = 8'h03;
    localparam logic [7:0] OP_ECCRD  = 8'h7c;
    localparam logic [7:0] OP_LOAD   = 8'h02;
    localparam logic [7:0] OP_LOADR  = 8'h84;
    localparam logic [7:0] OP_LOAD4  = 8'h32;
    localparam logic [7:0] OP_LOADR4 = 8'h34;
    localparam logic [7:0] OP_EXEC   = 8'h10;
    localparam logic [7:0] OP_ERASE  = 8'hd8;
    localparam logic [7:0] OP_RESET  = 8'hff;
    // Feature addresses
    localparam logic [7:0] FA_PROT = 8'ha0;
    localparam logic [7:0] FA_OTP  = 8'hb0;
    localparam logic [7:0] FA_STAT = 8'hc0;
    // Feature bit positions
    localparam int PRT_LOCK = 7;
    localparam int PRT_BP   = 3;
    localparam int PRT_INV  = 2;
    localparam int PRT_CMP  = 1;
    localparam int PRT_SP   = 0;
    localparam int OTP_EN   = 6;
    localparam int ECC_EN   = 4;
    localparam int STS_OIP  = 0;
    localparam int STS_WEL  = 1;
    localparam int STS_ECC  = 4;
    // Field values
    localparam logic [2:0] BP_NONE    = 3'h0;
    localparam logic [2:0] BP_BLK0    = 3'h6;
    localparam logic [2:0] BP_ALL     = 3'h7;
    localparam logic [3:0] ECC_MAXFIX = 4'h4;
    localparam logic [3:0] ECC_BAD    = 4'hf;
    localparam logic [1:0] SUM_FIX    = 2'h1;
    localparam logic [1:0] SUM_BAD    = 2'h2;
    localparam logic [11:0] COL_LIMIT = 12'h840;
    localparam logic [2:0] PART_MAX   = 3'h4;
    localparam logic [7:0] CACHE_FILL = 8'hff;
    localparam int SEGS      = 4;
    localparam int PAGE_BITS = 6;
    localparam int UID_HALF  = 4;
    // Byte positions inside a frame
    localparam logic [2:0] IX_CMD  = 3'h0;
    localparam logic [2:0] IX_FA   = 3'h1;
    localparam logic [2:0] IX_COLL = 3'h2;
    localparam logic [2:0] IX_SETE = 3'h3;
    localparam logic [2:0] IX_DATA = 3'h3;
    localparam logic [2:0] IX_ADRE = 3'h4;
    localparam logic [2:0] IX_MAX  = 3'h7;
    // Bit counter steps
    localparam logic [2:0] BIT_STEP  = 3'h1;
    localparam logic [2:0] BIT_QSTEP = 3'h4;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [2:0] BIT_QLAST = 3'h4;
    // Busy times
    localparam int CLK_MHZ       = 40;
    localparam int PROG_TIME_US  = 600;
    localparam int ERASE_TIME_US = 3500;
    localparam int READ_TIME_US  = 70;
    localparam int RESET_TIME_US = 5;
    localparam int PROG_CYC  = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
    localparam int READ_CYC  = READ_TIME_US * CLK_MHZ;
    localparam int RESET_CYC = RESET_TIME_US * CLK_MHZ;
    localparam int TMR_W     = 18;
    typedef enum logic {ST_READY, ST_BUSY} snd_state_t;
    typedef enum logic [1:0] {OPK_READ, OPK_PROG, OPK_ERASE, OPK_RESET}
        snd_opk_t;
endpackage

// ===== hdl/snd_top.sv
// What this block does
// - Identifier records: halves XOR to FFh
// - ECC read: opcode, dummy byte, status
// - Report worst of four segment results
// - Page read updates; reset clears to 00h
// - Low nibble codes, upper nibble zero
// - Write enable sets latch; else ignore
// - Discard bytes past 2112; four partials
// - Chip select high ends data loading
// - Execute: opcode, 24-bit address, busy
// - Erase one block; needs latch set
// - Misaligned chip select rejects erase
// - Erase busy flag, then latch cleared
// - Row address width follows density
// - Power-up: range all ones, rest zero
// - Lock bit with pin low freezes fields
// - Solid protect freezes until power cycle
// - Large density: top fraction table
// - Small density: invert, complement, block 0
// - Busy flag while read/program/erase/reset
// - Write disable and program/erase completion clear latch
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Link side, cleared whenever chip select is high
module snd_link
    import snd_pkg::*;
#(
    parameter logic [7:0] UID_SEED = 8'h5a // Arbitrary identifier seed
) (
    input  wire logic        i_sck,
    input  wire logic        i_rstn,
    input  wire logic        i_cs_n,
    input  wire logic [3:0]  i_sio,
    input  wire logic [33:0] i_core,
    output logic             o_so,
    output logic             o_so_oe,
    output logic             o_done,
    output logic [7:0]       o_val,
    output logic [11:0]      o_col,
    output logic             o_algn
);
    typedef struct packed {
        logic [7:0]  sh;
        logic [2:0]  bitn;
        logic [2:0]  nb;
        logic [7:0]  op;
        logic [7:0]  fa;
        logic [11:0] col;
        logic        quad;
        logic [7:0]  obuf;
        logic        oe;
        logic [33:0] s1;
        logic [33:0] s2;
    } snd_link_t;

    snd_link_t r;
    snd_link_t n;
    logic [7:0] val;
    logic       done;

    // Identifier byte: second half is the complement of the first
    function automatic logic [7:0] uid_byte(input logic [11:0] c);
        logic [7:0] b;
        b = UID_SEED + {4'h0, c[3:0]};
        return c[UID_HALF] ? ~b : b;
    endfunction

    // Feature byte by address, read repeats the same byte
    function automatic logic [7:0] feat(input logic [7:0] a,
                                        input logic [33:0] s);
        case (a)
            FA_PROT: feat = s[15:8];
            FA_OTP:  feat = s[23:16];
            FA_STAT: feat = s[7:0];
            default: feat = 8'h00;
        endcase
    endfunction

    // Byte assembly, column tracking and response shifting
    always_comb begin
        logic [7:0] nop;
        nop = r.op;
        n = r;
        n.s1 = i_core;
        n.s2 = r.s1;
        val = r.quad ? {r.sh[3:0], i_sio} : {r.sh[6:0], i_sio[0]};
        done = r.quad ? (r.bitn == BIT_QLAST) : (r.bitn == BIT_LAST);
        n.sh = val;
        n.bitn = done ? 3'h0 : r.bitn + (r.quad ? BIT_QSTEP : BIT_STEP);
        n.obuf = {r.obuf[6:0], 1'b0};
        if (done) begin
            if (r.nb == IX_CMD) begin
                n.op = val;
                nop = val;
            end
            if (r.nb == IX_FA) begin
                n.fa = val;
                n.col[11:8] = val[3:0];
            end
            if (r.nb == IX_COLL) begin
                n.col[7:0] = val;
                // Four-wire data only when not hardware locked
                n.quad = r.s2[33] && (r.op == OP_LOAD4 || r.op == OP_LOADR4);
            end
            // Column stops at the page end, later bytes dropped
            if (r.nb >= IX_DATA && r.col != COL_LIMIT) begin
                n.col = r.col + 12'h001;
            end
            if (r.nb != IX_MAX) begin
                n.nb = r.nb + 3'h1;
            end
            if ((nop == OP_GETF) && r.nb >= IX_FA) begin
                n.oe = 1'b1;
                n.obuf = feat((r.nb == IX_FA) ? val : r.fa, r.s2);
            end
            if ((nop == OP_ECCRD) && r.nb >= IX_FA) begin
                n.oe = 1'b1;
                n.obuf = r.s2[31:24];
            end
            if ((nop == OP_RCACHE) && r.nb >= IX_DATA) begin
                n.oe = 1'b1;
                n.obuf = r.s2[32] ? uid_byte(r.col) : CACHE_FILL;
            end
        end
    end

    // Chip select high clears the frame at once
    always_ff @(posedge i_sck or negedge i_rstn or posedge i_cs_n) begin
        if (!i_rstn || i_cs_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_so    = r.obuf[7];
    assign o_so_oe = r.oe;
    assign o_done  = done;
    assign o_val   = val;
    assign o_col   = n.col;
    assign o_algn  = (n.bitn == 3'h0);
endmodule

////////////////////////////////////////////////////////////////////////////////
// Link side, kept across frames for the core to read
module snd_snap (
    input  wire logic        i_sck,
    input  wire logic        i_rstn,
    input  wire logic        i_done,
    input  wire logic [7:0]  i_val,
    input  wire logic [11:0] i_col,
    input  wire logic        i_algn,
    output logic             o_tog,
    output logic [7:0]       o_dat,
    output logic [11:0]      o_col,
    output logic             o_algn
);
    typedef struct packed {
        logic        tog;
        logic [7:0]  dat;
        logic [11:0] col;
        logic        algn;
    } snd_snap_t;

    snd_snap_t r;
    snd_snap_t n;

    // Byte toggles for the core; data holds a whole byte time
    always_comb begin
        n = r;
        n.col = i_col;
        n.algn = i_algn;
        if (i_done) begin
            n.tog = ~r.tog;
            n.dat = i_val;
        end
    end

    always_ff @(posedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_tog  = r.tog;
    assign o_dat  = r.dat;
    assign o_col  = r.col;
    assign o_algn = r.algn;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Command sequencer on the reference clock
module snd_top
    import snd_pkg::*;
#(
    parameter int         PROG_CYC_P  = PROG_CYC,
    parameter int         ERASE_CYC_P = ERASE_CYC,
    parameter bit         SMALL_DENS  = 1'b0,
    parameter logic [7:0] UID_SEED    = 8'h5a // Arbitrary value
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_sck,
    input  wire logic        i_cs_n,
    input  wire logic [3:0]  i_sio,
    input  wire logic        i_wp_n,
    input  wire logic [15:0] i_seg_err,
    output logic             o_so,
    output logic             o_so_oe,
    output logic             o_busy,
    output logic             o_read_go,
    output logic             o_prog_go,
    output logic             o_erase_go,
    output logic [16:0]      o_row,
    output logic [11:0]      o_load_cols
);
    localparam int BLK_W = SMALL_DENS ? 10 : 11;

    typedef struct packed {
        logic cs1, cs2, cs3, cs4, tg1, tg2, tg3, wp1, wp2;
        logic [12:0] q1;
        logic [12:0] q2;
        logic [2:0]  nb;
        logic [7:0]  op;
        logic [23:0] addr;
        snd_state_t  st;
        snd_opk_t    opk;
        logic [TMR_W-1:0] tmr;
        logic operation_in_progress, write_latch_flag, lock, inv, cmp, sp, otp, ecen, uid;
        logic [7:0]  ecc;
        logic [2:0]  bp;
        logic [2:0]  part;
        logic [16:0] prow;
        logic [16:0] row;
        logic [11:0] cols;
        logic rd_go, pg_go, er_go;
    } snd_core_t;

    snd_core_t r;
    snd_core_t n;
    logic [33:0] core_out;
    logic        done, algn, tog, salgn;
    logic [7:0]  val, dat;
    logic [11:0] lcol, scol;
    logic        hw_lock, frozen, fend;
    logic [16:0] rowa;

    // Worst segment wins; an uncorrectable one dominates
    function automatic logic [3:0] ecc_max(input logic [15:0] s);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < SEGS; i++) begin
            // Counts beyond the correctable limit report as lost
            if (s[i*4+:4] > ECC_MAXFIX || m == ECC_BAD) begin
                m = ECC_BAD;
            end else if (s[i*4+:4] > m) begin
                m = s[i*4+:4];
            end
        end
        return m;
    endfunction

    // Block protection lookup
    function automatic logic prot_hit(input logic [16:0] row,
                                      input logic [2:0] bp,
                                      input logic inv, cmp);
        logic [10:0] blk, top, mask;
        logic        frac;
        int          k;
        blk = row[16:PAGE_BITS];
        k = int'(BP_ALL - bp);
        top = blk >> (BLK_W - k);
        mask = 11'h7ff >> (11 - k);
        frac = inv ? (top == 11'h000) : (top == mask);
        if (bp == BP_NONE) begin
            prot_hit = 1'b0;
        end else if (bp == BP_ALL) begin
            prot_hit = 1'b1;
        end else if (!SMALL_DENS) begin
            prot_hit = top == mask;
        end else if (cmp && bp == BP_BLK0) begin
            prot_hit = blk == 11'h000;
        end else begin
            prot_hit = cmp ? !frac : frac;
        end
    endfunction

    snd_link #(.UID_SEED(UID_SEED)) u_link (
        .i_sck   (i_sck),
        .i_rstn  (i_rstn),
        .i_cs_n  (i_cs_n),
        .i_sio   (i_sio),
        .i_core  (core_out),
        .o_so    (o_so),
        .o_so_oe (o_so_oe),
        .o_done  (done),
        .o_val   (val),
        .o_col   (lcol),
        .o_algn  (algn)
    );

    snd_snap u_snap (
        .i_sck  (i_sck),
        .i_rstn (i_rstn),
        .i_done (done),
        .i_val  (val),
        .i_col  (lcol),
        .i_algn (algn),
        .o_tog  (tog),
        .o_dat  (dat),
        .o_col  (scol),
        .o_algn (salgn)
    );

    // Lock state; four-wire loads take single-wire data while hardware locked
    assign hw_lock = r.lock && !r.wp2 && !(SMALL_DENS && r.sp);
    assign frozen  = hw_lock || (SMALL_DENS && r.sp);
    // One stage later than the byte toggle, so the last byte lands first
    assign fend    = r.cs3 && !r.cs4;
    assign rowa    = SMALL_DENS ? {1'b0, r.addr[15:0]} : r.addr[16:0];

    // Feature bytes exported to the link, each bit resynchronised there
    always_comb begin
        core_out = '0;
        core_out[STS_OIP] = r.operation_in_progress;
        core_out[STS_WEL] = r.write_latch_flag;
        core_out[STS_ECC+:2] = (r.ecc[3:0] == ECC_BAD) ? SUM_BAD :
                               (r.ecc[3:0] != 4'h0) ? SUM_FIX : 2'h0;
        core_out[8+PRT_LOCK] = r.lock;
        core_out[8+PRT_BP+:3] = r.bp;
        core_out[8+PRT_INV] = r.inv;
        core_out[8+PRT_CMP] = r.cmp;
        core_out[8+PRT_SP] = r.sp;
        core_out[16+OTP_EN] = r.otp;
        core_out[16+ECC_EN] = r.ecen;
        core_out[31:24] = r.ecc;
        core_out[32] = r.uid && r.otp;
        core_out[33] = !hw_lock;
    end

    // Frame decode, busy timing and protection fields
    always_comb begin
        n = r;
        n.rd_go = 1'b0;
        n.pg_go = 1'b0;
        n.er_go = 1'b0;
        n.cs1 = i_cs_n;
        n.cs2 = r.cs1;
        n.cs3 = r.cs2;
        n.cs4 = r.cs3;
        n.tg1 = tog;
        n.tg2 = r.tg1;
        n.tg3 = r.tg2;
        n.q1 = {salgn, scol};
        n.q2 = r.q1;
        n.wp1 = i_wp_n;
        n.wp2 = r.wp1;
        if (r.cs3) begin
            n.nb = 3'h0;
        end else if (r.tg2 != r.tg3) begin
            if (r.nb == IX_CMD) begin
                n.op = dat;
            end else begin
                n.addr = {r.addr[15:0], dat};
            end
            if (r.nb != IX_MAX) begin
                n.nb = r.nb + 3'h1;
            end
        end
        // Busy countdown and completion effects
        if (r.st == ST_BUSY) begin
            if (r.tmr == '0) begin
                n.st = ST_READY;
                unique case (r.opk)
                    OPK_READ: begin
                        n.ecc = r.ecen ? {4'h0, ecc_max(i_seg_err)}
                                       : 8'h00;
                        n.uid = r.otp && (r.row == 17'h00000);
                    end
                    OPK_PROG:  n.write_latch_flag = 1'b0;
                    OPK_ERASE: n.write_latch_flag = 1'b0;
                    OPK_RESET: n.write_latch_flag = r.write_latch_flag;
                endcase
            end else begin
                n.tmr = r.tmr - 1'b1;
            end
        end
        // Actions taken when chip select rises
        if (fend && r.op == OP_RESET && r.nb == IX_FA) begin
            n.ecc = 8'h00;
            n.st = ST_BUSY;
            n.opk = OPK_RESET;
            n.tmr = TMR_W'(RESET_CYC - 1);
        end else if (fend && r.st == ST_READY) begin
            case (r.op)
                OP_WREN: n.write_latch_flag = 1'b1;
                OP_WRDI: n.write_latch_flag = 1'b0;
                OP_SETF: if (r.nb == IX_SETE) begin
                    if (r.addr[15:8] == FA_PROT && !frozen) begin
                        n.lock = r.addr[PRT_LOCK];
                        n.bp = r.addr[PRT_BP+:3];
                        n.inv = SMALL_DENS && r.addr[PRT_INV];
                        n.cmp = SMALL_DENS && r.addr[PRT_CMP];
                        n.sp = SMALL_DENS && r.addr[PRT_SP];
                    end
                    if (r.addr[15:8] == FA_OTP) begin
                        n.otp = r.addr[OTP_EN];
                        n.ecen = r.addr[ECC_EN];
                    end
                end
                OP_PRD: if (r.nb == IX_ADRE) begin
                    n.st = ST_BUSY;
                    n.opk = OPK_READ;
                    n.tmr = TMR_W'(READ_CYC - 1);
                    n.row = rowa;
                    n.rd_go = 1'b1;
                end
                OP_LOAD, OP_LOADR, OP_LOAD4, OP_LOADR4: if (r.write_latch_flag) begin
                    n.cols = r.q2[11:0];
                end
                OP_EXEC: if (r.nb == IX_ADRE && r.write_latch_flag &&
                             !prot_hit(rowa, r.bp, r.inv, r.cmp) &&
                             (rowa != r.prow || r.part < PART_MAX)) begin
                    n.st = ST_BUSY;
                    n.opk = OPK_PROG;
                    n.tmr = TMR_W'(PROG_CYC_P - 1);
                    n.part = ((rowa == r.prow) ? r.part : 3'h0) + 3'h1;
                    n.prow = rowa;
                    n.row = rowa;
                    n.pg_go = 1'b1;
                end
                OP_ERASE: if (r.nb == IX_ADRE && r.q2[12] && r.write_latch_flag &&
                              !prot_hit(rowa, r.bp, r.inv, r.cmp)) begin
                    n.st = ST_BUSY;
                    n.opk = OPK_ERASE;
                    n.tmr = TMR_W'(ERASE_CYC_P - 1);
                    n.part = 3'h0;
                    n.row = rowa;
                    n.er_go = 1'b1;
                end
                default: n.op = r.op;
            endcase
        end
        n.operation_in_progress = (n.st == ST_BUSY);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
            r.bp <= BP_ALL;
            r.ecen <= 1'b1;
            r.cs1 <= 1'b1;
            r.cs2 <= 1'b1;
            r.cs3 <= 1'b1;
            r.cs4 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_busy      = r.operation_in_progress;
    assign o_read_go   = r.rd_go;
    assign o_prog_go   = r.pg_go;
    assign o_erase_go  = r.er_go;
    assign o_row       = r.row;
    assign o_load_cols = r.cols;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_fend(logic [7:0] o);
        fend && r.op == o && r.st == ST_READY;
    endsequence

    a_wel_set: assert property (s_fend(OP_WREN) |=> r.write_latch_flag)
        else $error("write latch not set");
    a_wel_clear: assert property (s_fend(OP_WRDI) |=> !r.write_latch_flag)
        else $error("write latch not cleared");
    a_ecc_reset: assert property (fend && r.op == OP_RESET &&
        r.nb == IX_FA |=> r.ecc == 8'h00 && r.operation_in_progress)
        else $error("reset did not clear ecc");
    a_ecc_codes: assert property (r.ecc[7:4] == 4'h0 &&
        (r.ecc[3:0] <= ECC_MAXFIX || r.ecc[3:0] == ECC_BAD))
        else $error("illegal ecc code");
    a_ecc_worst: assert property (r.st == ST_BUSY &&
        r.opk == OPK_READ && r.tmr == '0 && r.ecen && !fend
        |=> r.ecc[3:0] == ecc_max($past(i_seg_err)))
        else $error("ecc not worst segment");
    a_erase_wel: assert property ($fell(r.operation_in_progress) &&
        r.opk == OPK_ERASE |-> !r.write_latch_flag)
        else $error("latch kept after erase");
    a_erase_busy: assert property ($rose(r.er_go) |-> r.operation_in_progress[*8])
        else $error("erase busy too short");
    a_erase_align: assert property ($rose(r.er_go) |->
        $past(r.q2[12]) && $past(r.write_latch_flag))
        else $error("erase taken unaligned");
    a_hw_freeze: assert property (hw_lock && fend &&
        r.op == OP_SETF |=> $stable(r.bp) && $stable(r.inv) &&
        $stable(r.cmp))
        else $error("locked fields changed");
    a_sp_sticky: assert property (r.sp |=> r.sp)
        else $error("solid protect dropped");
endmodule

// ===== verif/snd_host_model.sv
`timescale 1ns/1ps
// Host controller model, mode 0, MSB first; sck runs only inside frames
module snd_host_model (
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_sio,
    input  wire logic  i_so
);
    logic [7:0] rd_q[$];

    // Idle: chip select high, clock parked low
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_sio  = 4'h0;
    end

    // Sends tx, clocks nrd bytes back, then xbits stray bits
    task automatic frame(input logic [7:0] tx[$], input int nrd,
                         input int xbits);
        logic [7:0] sh;
        logic [7:0] rx;
        int         nb;
        nb = 8 * (tx.size() + nrd) + xbits;
        rx = 8'h00;
        rd_q.delete();
        o_cs_n <= 1'b0;
        #20;
        for (int k = 0; k < nb; k++) begin
            sh = (k / 8 < tx.size()) ? tx[k / 8] : 8'hff;
            o_sio[0] <= sh[7 - k % 8];
            #7.5;
            // Read data is held from the previous rise, take it here
            rx = {rx[6:0], i_so};
            o_sck <= 1'b1;
            #7.5;
            o_sck <= 1'b0;
            if (k % 8 == 7 && k / 8 >= tx.size()) begin
                rd_q.push_back(rx);
            end
        end
        #7.5;
        o_cs_n <= 1'b1;
        // Released lines must not keep showing the last bit
        o_sio  <= ~o_sio;
        #200;
    endtask
endmodule

// ===== verif/serial_nand_program_erase_protect_tb_top.sv
`timescale 1ns/1ps
module serial_nand_program_erase_protect_tb_top;
    import snd_pkg::*;
    logic        ref_clk    = 1'b0;
    logic        rstn       = 1'b0;
    logic        wp_n       = 1'b1;
    logic [15:0] seg_err    = 16'h0000;
    logic        sck, cs_n, so, so_oe, busy, rd_go, pg_go, er_go;
    logic [3:0]  sio;
    logic [16:0] row;
    logic [11:0] cols;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          n_rd       = 0;
    int          n_pg       = 0;
    int          n_er       = 0;

    // Short busy times keep the run brief
    snd_top #(.PROG_CYC_P(20), .ERASE_CYC_P(30)) dut (
        .i_ref_clk  (ref_clk),
        .i_rstn     (rstn),
        .i_sck      (sck),
        .i_cs_n     (cs_n),
        .i_sio      (sio),
        .i_wp_n     (wp_n),
        .i_seg_err  (seg_err),
        .o_so       (so),
        .o_so_oe    (so_oe),
        .o_busy     (busy),
        .o_read_go  (rd_go),
        .o_prog_go  (pg_go),
        .o_erase_go (er_go),
        .o_row      (row),
        .o_load_cols(cols)
    );
    snd_host_model host (
        .o_sck (sck),
        .o_cs_n(cs_n),
        .o_sio (sio),
        .i_so  (so)
    );

    // 40 MHz reference clock
    always #12.5 ref_clk = ~ref_clk;
    // Start pulses last one cycle, so tally them as they come
    always @(posedge ref_clk) begin
        n_rd <= n_rd + int'(rd_go);
        n_pg <= n_pg + int'(pg_go);
        n_er <= n_er + int'(er_go);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] tx[$]);
        host.frame(tx, 0, 0);
    endtask
    task automatic getf(input logic [7:0] fa, exp, input string nm);
        host.frame({OP_GETF, fa}, 1, 0);
        check(nm, host.rd_q[0], exp);
    endtask
    task automatic eccrd(input logic [7:0] exp);
        host.frame({OP_ECCRD, 8'h00}, 1, 0);
        check("ecc", host.rd_q[0], exp);
    endtask
    // Bounded wait, a hang shows as a mismatch
    task automatic wait_idle;
        int n;
        n = 0;
        // Sample away from the edge that moves busy
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        check("idle", busy, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_start;
        check("busy", busy, 1'b0);
        check("oe", so_oe, 1'b0);
        getf(FA_PROT, 8'h38, "prot");
        eccrd(8'h00);
        send({OP_WREN});
        getf(FA_STAT, 8'h02, "latch");
        send({OP_WRDI});
        getf(FA_STAT, 8'h00, "latch");
    endtask
    task automatic t_ecc;
        logic [15:0] se[3] = '{16'h0201, 16'h4000, 16'h0f10};
        logic [7:0]  ex[3] = '{8'h02, 8'h04, 8'h0f};
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk) seg_err <= se[k];
            send({OP_PRD, 8'h00, 8'h00, 8'h00});
            check("busy", busy, 1'b1);
            wait_idle;
            eccrd(ex[k]);
        end
        check("reads", n_rd, 3);
        getf(FA_STAT, 8'h20, "status");
        send({OP_RESET});
        wait_idle;
        eccrd(8'h00);
    endtask
    task automatic t_erase;
        send({OP_SETF, FA_PROT, 8'h00});
        getf(FA_PROT, 8'h00, "prot");
        send({OP_ERASE, 8'h00, 8'h00, 8'h05});
        send({OP_WREN});
        host.frame({OP_ERASE, 8'h00, 8'h00, 8'h05}, 0, 3);
        check("no erase", n_er, 0);
        send({OP_ERASE, 8'h00, 8'h00, 8'h05});
        check("erase", n_er, 1);
        check("erase busy", busy, 1'b1);
        check("row", row, 17'h00005);
        wait_idle;
        getf(FA_STAT, 8'h00, "latch");
    endtask
    task automatic t_prog;
        send({OP_LOAD, 8'h08, 8'h3e, 8'h11, 8'h22, 8'h33, 8'h44});
        send({OP_EXEC, 8'h00, 8'h00, 8'h07});
        check("no prog", n_pg, 0);
        send({OP_WREN});
        send({OP_LOAD, 8'h08, 8'h3e, 8'h11, 8'h22, 8'h33, 8'h44});
        check("cols", cols, COL_LIMIT);
        send({OP_EXEC, 8'h00, 8'h00, 8'h07});
        check("prog", n_pg, 1);
        check("prog row", row, 17'h00007);
        wait_idle;
        getf(FA_STAT, 8'h00, "latch");
        // Three more partials on row 7 pass, the fifth is refused
        for (int i = 0; i < 4; i++) begin
            send({OP_WREN});
            send({OP_EXEC, 8'h00, 8'h00, 8'h07});
            wait_idle;
        end
        check("partials", n_pg, 4);
        // One single-wire byte time is four bytes in four-wire mode
        send({OP_WREN});
        send({OP_LOAD4, 8'h00, 8'h10, 8'h00});
        check("quad cols", cols, 12'h014);
        send({OP_EXEC, 8'h00, 8'h00, 8'h08});
        check("quad prog", n_pg, 5);
        wait_idle;
    endtask
    task automatic t_lock;
        send({OP_SETF, FA_PROT, 8'h80});
        @(posedge ref_clk) wp_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        send({OP_SETF, FA_PROT, 8'h38});
        getf(FA_PROT, 8'h80, "hw lock");
        @(posedge ref_clk) wp_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        send({OP_SETF, FA_PROT, 8'h38});
        getf(FA_PROT, 8'h38, "unlock");
    endtask
    task automatic t_uid;
        send({OP_SETF, FA_OTP, 8'h40});
        send({OP_PRD, 8'h00, 8'h00, 8'h00});
        wait_idle;
        host.frame({OP_RCACHE, 8'h00, 8'h00, 8'h00}, 32, 0);
        for (int i = 0; i < 16; i++) begin
            check("uid", host.rd_q[i] ^ host.rd_q[i + 16], 8'hff);
        end
        send({OP_SETF, FA_OTP, 8'h10});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_start;
        t_ecc;
        t_erase;
        t_prog;
        t_lock;
        t_uid;
        close_out;
    end
    // Watchdog, well beyond four page reads and the short busy times
    initial begin
        #2000000;
        num_errors++;
        close_out;
    end
endmodule
